// ---- hw/lla_line_loop.sv ----
// Purpose: Loopback steering, all-ones generator and attenuator FIFOs.
// Assumes: System side on clock; line side on transmit_timing_clock.
// Notes:   Two gray-pointer FIFOs carry rails between the two domains.
`timescale 1ns/1ps

module lla_async_fifo #(
	parameter int  WIDTH = 2,
	parameter int  DEPTH = 8,
	localparam int AW    = $clog2(DEPTH)
) (
	input  wire logic             wr_clock,
	input  wire logic             wr_reset,
	input  wire logic             wr_enable,
	input  wire logic             wr_valid,
	input  wire logic [WIDTH-1:0] wr_data,
	output logic                  wr_ready,
	input  wire logic             rd_clock,
	input  wire logic             rd_reset,
	input  wire logic             rd_enable,
	output logic                  rd_valid,
	output logic [WIDTH-1:0]      rd_data,
	input  wire logic             rd_ready,
	output logic [AW:0]           rd_level
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wbin_reg;
	logic [AW:0]      wgray_reg;
	logic [AW:0]      rbin_reg;
	logic [AW:0]      rgray_reg;
	logic [AW:0]      wq1_reg;
	logic [AW:0]      wq2_reg;
	logic [AW:0]      rq1_reg;
	logic [AW:0]      rq2_reg;
	logic [AW:0]      wbin_next;
	logic [AW:0]      rbin_next;
	logic             wr_fire;
	logic             rd_fire;

	function automatic logic [AW:0] to_bin(input logic [AW:0] g);
		logic [AW:0] b;
		b[AW] = g[AW];
		for (int i = AW - 1; i >= 0; i--) begin
			b[i] = b[i + 1] ^ g[i];
		end
		return b;
	endfunction : to_bin

	// Full when gray pointers differ only in the two top bits
	assign wr_ready  = wgray_reg != {~rq2_reg[AW:AW-1], rq2_reg[AW-2:0]};
	assign wr_fire   = wr_enable && wr_valid && wr_ready;
	assign wbin_next = wbin_reg + (AW+1)'(1);
	assign rd_valid  = rgray_reg != wq2_reg;
	assign rd_fire   = rd_enable && rd_valid && rd_ready;
	assign rbin_next = rbin_reg + (AW+1)'(1);
	assign rd_data   = mem_reg[rbin_reg[AW-1:0]];
	assign rd_level  = to_bin(wq2_reg) - rbin_reg;

	always_ff @(posedge wr_clock) begin
		if (wr_reset) begin
			wbin_reg  <= '0;
			wgray_reg <= '0;
		end else if (wr_fire) begin
			wbin_reg  <= wbin_next;
			wgray_reg <= wbin_next ^ (wbin_next >> 1);
		end
	end

	always_ff @(posedge wr_clock) begin
		if (wr_fire) begin
			mem_reg[wbin_reg[AW-1:0]] <= wr_data;
		end
	end

	always_ff @(posedge wr_clock) begin
		if (wr_reset) begin
			rq1_reg <= '0;
			rq2_reg <= '0;
		end else if (wr_enable) begin
			rq1_reg <= rgray_reg;
			rq2_reg <= rq1_reg;
		end
	end

	always_ff @(posedge rd_clock) begin
		if (rd_reset) begin
			rbin_reg  <= '0;
			rgray_reg <= '0;
		end else if (rd_fire) begin
			rbin_reg  <= rbin_next;
			rgray_reg <= rbin_next ^ (rbin_next >> 1);
		end
	end

	always_ff @(posedge rd_clock) begin
		if (rd_reset) begin
			wq1_reg <= '0;
			wq2_reg <= '0;
		end else if (rd_enable) begin
			wq1_reg <= wgray_reg;
			wq2_reg <= wq1_reg;
		end
	end
endmodule : lla_async_fifo

module lla_line_loop (
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       clock_enable,
	input  wire logic       transmit_timing_clock,
	input  wire logic       host_mode,
	input  wire logic       far_loop_select,
	input  wire logic       near_loop_select,
	input  wire logic       send_all_ones,
	input  wire logic       far_loop_bit,
	input  wire logic       near_loop_bit,
	input  wire logic       all_ones_bit,
	input  wire logic [1:0] ja_mode,
	input  wire logic       system_transmit_clock,
	input  wire logic       transmit_positive_rail,
	input  wire logic       transmit_negative_rail,
	input  wire logic       line_rx_positive_in,
	input  wire logic       line_rx_negative_in,
	output logic            receive_clock_out,
	output logic            receive_positive_rail,
	output logic            receive_negative_rail,
	output logic            line_tx_positive_out,
	output logic            line_tx_negative_out,
	output logic            tx_ready,
	output logic [1:0]      loop_mode_status
);
	localparam int W = lla_pkg::LLA_RAIL_W;

	// System domain
	logic [6:0]          pin_s1_reg;
	logic [6:0]          pin_s2_reg;
	logic                system_transmit_clock_prev_reg;
	lla_pkg::lla_mode_e  mode_reg;
	lla_pkg::lla_mode_e  mode_next;
	lla_pkg::lla_ja_e    ja_reg;
	logic                aos_reg;
	logic                far_sel;
	logic                near_sel;
	logic                tx_edge;
	logic                tx_push;
	logic                tx_wr_ready;
	logic                rx_valid;
	logic [W-1:0]        rx_data;
	logic [3:0]          rx_level;
	logic                rx_started_reg;
	logic                rx_pace_reg;
	logic                rx_pop;
	logic                receive_clock_out_reg;
	logic [W-1:0]        rxrail_reg;
	logic                tx_ready_reg;

	// Link domain
	logic [6:0]          lk_s1_reg;
	logic [6:0]          lk_s2_reg;
	logic [W-1:0]        lrx_s1_reg;
	logic [W-1:0]        lrx_s2_reg;
	logic                lk_reset;
	logic                lk_ce;
	logic                lk_aos;
	lla_pkg::lla_mode_e  lk_mode;
	lla_pkg::lla_ja_e    lk_ja;
	logic [W-1:0]        rx_bit;
	logic                rx_push;
	logic                tx_valid;
	logic [W-1:0]        tx_data;
	logic [3:0]          tx_level;
	logic                tx_started_reg;
	logic                tx_pop;
	logic                ami_phase_reg;
	logic [W-1:0]        line_tx_reg;
	logic [W-1:0]        line_tx_next;

	// Pins pass two flops before use
	always_ff @(posedge clock) begin
		if (reset) begin
			pin_s1_reg <= lla_pkg::LLA_PINS_RESET;
			pin_s2_reg <= lla_pkg::LLA_PINS_RESET;
		end else if (clock_enable) begin
			pin_s1_reg <= {host_mode, far_loop_select, near_loop_select,
				send_all_ones, system_transmit_clock,
				transmit_positive_rail, transmit_negative_rail};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	assign far_sel  = pin_s2_reg[6] ? far_loop_bit : pin_s2_reg[5];
	assign near_sel = pin_s2_reg[6] ? near_loop_bit : pin_s2_reg[4];
	assign mode_next = lla_pkg::lla_mode_e'({far_sel, near_sel});

	always_ff @(posedge clock) begin
		if (reset) begin
			mode_reg <= lla_pkg::LLA_NORMAL;
			ja_reg   <= lla_pkg::LLA_JA_OFF;
			aos_reg  <= 1'b0;
		end else if (clock_enable) begin
			mode_reg <= mode_next;
			ja_reg   <= lla_pkg::lla_ja_e'(ja_mode);
			aos_reg  <= pin_s2_reg[6] ? all_ones_bit : pin_s2_reg[3];
		end
	end

	// Mapper clock edges mark transmit bits, gapped or not
	assign tx_edge = pin_s2_reg[2] && !system_transmit_clock_prev_reg;
	assign tx_push = tx_edge && (mode_reg == lla_pkg::LLA_NORMAL ||
		mode_reg == lla_pkg::LLA_ANALOG);

	always_ff @(posedge clock) begin
		if (reset) begin
			system_transmit_clock_prev_reg <= 1'b0;
			tx_ready_reg   <= 1'b0;
		end else if (clock_enable) begin
			system_transmit_clock_prev_reg <= pin_s2_reg[2];
			tx_ready_reg   <= tx_wr_ready;
		end
	end

	// Receive drain: one bit every second cycle once primed
	assign rx_pop = rx_started_reg && rx_valid && !rx_pace_reg;

	always_ff @(posedge clock) begin
		if (reset) begin
			rx_started_reg <= 1'b0;
		end else if (clock_enable) begin
			if (!rx_valid) begin
				rx_started_reg <= 1'b0;
			end else if (ja_reg != lla_pkg::LLA_JA_RX ||
				rx_level >= lla_pkg::LLA_PREFILL) begin
				rx_started_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			rx_pace_reg <= 1'b0;
			receive_clock_out_reg   <= 1'b0;
			rxrail_reg  <= lla_pkg::LLA_RAILS_IDLE;
		end else if (clock_enable) begin
			if (mode_reg == lla_pkg::LLA_DIGITAL) begin
				rx_pace_reg <= 1'b0;
				receive_clock_out_reg   <= pin_s2_reg[2];
				rxrail_reg  <= pin_s2_reg[1:0];
			end else if (rx_pop) begin
				rx_pace_reg <= 1'b1;
				receive_clock_out_reg   <= 1'b1;
				rxrail_reg  <= rx_data;
			end else begin
				rx_pace_reg <= 1'b0;
				receive_clock_out_reg   <= 1'b0;
			end
		end
	end

	assign receive_clock_out     = receive_clock_out_reg;
	assign receive_positive_rail = rxrail_reg[1];
	assign receive_negative_rail = rxrail_reg[0];
	assign tx_ready              = tx_ready_reg;
	assign loop_mode_status      = mode_reg;

	// Levels into the link domain
	always_ff @(posedge transmit_timing_clock) begin
		lk_s1_reg <= {reset, clock_enable, aos_reg, mode_reg, ja_reg};
		lk_s2_reg <= lk_s1_reg;
	end

	assign lk_reset = lk_s2_reg[6];
	assign lk_ce    = lk_s2_reg[5];
	assign lk_aos   = lk_s2_reg[4];
	assign lk_mode  = lla_pkg::lla_mode_e'(lk_s2_reg[3:2]);
	assign lk_ja    = lla_pkg::lla_ja_e'(lk_s2_reg[1:0]);

	always_ff @(posedge transmit_timing_clock) begin
		if (lk_reset) begin
			lrx_s1_reg <= lla_pkg::LLA_RAILS_IDLE;
			lrx_s2_reg <= lla_pkg::LLA_RAILS_IDLE;
		end else if (lk_ce) begin
			lrx_s1_reg <= {line_rx_positive_in, line_rx_negative_in};
			lrx_s2_reg <= lrx_s1_reg;
		end
	end

	// Analog loop takes the driven line bit, not the line pins
	assign rx_bit = (lk_mode == lla_pkg::LLA_ANALOG) ?
		line_tx_reg : lrx_s2_reg;
	assign rx_push = lk_mode != lla_pkg::LLA_DIGITAL;

	// Transmit attenuator primes before draining; deeper for de-sync
	always_ff @(posedge transmit_timing_clock) begin
		if (lk_reset) begin
			tx_started_reg <= 1'b0;
		end else if (lk_ce) begin
			if (!tx_valid) begin
				tx_started_reg <= 1'b0;
			end else if (lk_ja == lla_pkg::LLA_JA_DESYNC) begin
				if (tx_level >= lla_pkg::LLA_PREFILL_DESYNC) begin
					tx_started_reg <= 1'b1;
				end
			end else if (lk_ja != lla_pkg::LLA_JA_TX ||
				tx_level >= lla_pkg::LLA_PREFILL) begin
				tx_started_reg <= 1'b1;
			end
		end
	end

	assign tx_pop = tx_started_reg && tx_valid && !lk_aos &&
		(lk_mode == lla_pkg::LLA_NORMAL || lk_mode == lla_pkg::LLA_ANALOG);

	always_comb begin
		line_tx_next = lla_pkg::LLA_RAILS_IDLE;
		if (lk_aos) begin
			line_tx_next = ami_phase_reg ? lla_pkg::LLA_AMI_NEG :
				lla_pkg::LLA_AMI_POS;
		end else begin
			unique case (lk_mode)
				lla_pkg::LLA_REMOTE: line_tx_next = lrx_s2_reg;
				lla_pkg::LLA_DIGITAL: line_tx_next = lla_pkg::LLA_RAILS_IDLE;
				lla_pkg::LLA_NORMAL,
				lla_pkg::LLA_ANALOG: begin
					if (tx_pop) begin
						line_tx_next = tx_data;
					end
				end
			endcase
		end
	end

	always_ff @(posedge transmit_timing_clock) begin
		if (lk_reset) begin
			ami_phase_reg <= 1'b0;
			line_tx_reg   <= lla_pkg::LLA_RAILS_IDLE;
		end else if (lk_ce) begin
			ami_phase_reg <= lk_aos ? !ami_phase_reg : 1'b0;
			line_tx_reg   <= line_tx_next;
		end
	end

	assign line_tx_positive_out = line_tx_reg[1];
	assign line_tx_negative_out = line_tx_reg[0];

	lla_async_fifo #(
		.WIDTH (W),
		.DEPTH (lla_pkg::LLA_FIFO_DEPTH)
	) u_tx_fifo (
		.wr_clock  (clock),
		.wr_reset  (reset),
		.wr_enable (clock_enable),
		.wr_valid  (tx_push),
		.wr_data   (pin_s2_reg[1:0]),
		.wr_ready  (tx_wr_ready),
		.rd_clock  (transmit_timing_clock),
		.rd_reset  (lk_reset),
		.rd_enable (lk_ce),
		.rd_valid  (tx_valid),
		.rd_data   (tx_data),
		.rd_ready  (tx_pop),
		.rd_level  (tx_level)
	);

	lla_async_fifo #(
		.WIDTH (W),
		.DEPTH (lla_pkg::LLA_FIFO_DEPTH)
	) u_rx_fifo (
		.wr_clock  (transmit_timing_clock),
		.wr_reset  (lk_reset),
		.wr_enable (lk_ce),
		.wr_valid  (rx_push),
		.wr_data   (rx_bit),
		.wr_ready  (),
		.rd_clock  (clock),
		.rd_reset  (reset),
		.rd_enable (clock_enable),
		.rd_valid  (rx_valid),
		.rd_data   (rx_data),
		.rd_ready  (rx_pop),
		.rd_level  (rx_level)
	);

	chk_both_analog: assert property (
		@(posedge clock) disable iff (reset)
		(clock_enable && pin_s2_reg[6] && far_loop_bit && near_loop_bit)
		|=> mode_reg == lla_pkg::LLA_ANALOG)
		else $error("both selects did not give analog loop");

	chk_digital_rx_clock: assert property (
		@(posedge clock) disable iff (reset)
		(clock_enable && mode_reg == lla_pkg::LLA_DIGITAL)
		|=> receive_clock_out == $past(pin_s2_reg[2])
			&& receive_positive_rail == $past(pin_s2_reg[1]))
		else $error("digital loop did not forward transmit clock");

	chk_no_push_digital: assert property (
		@(posedge clock) disable iff (reset)
		mode_reg == lla_pkg::LLA_DIGITAL |-> !tx_push)
		else $error("transmit data queued in digital loop");

	chk_remote_ignores_tx: assert property (
		@(posedge clock) disable iff (reset)
		mode_reg == lla_pkg::LLA_REMOTE |-> !tx_push)
		else $error("transmit data queued in remote loop");

	chk_all_ones_bit: assert property (
		@(posedge clock) disable iff (reset)
		(clock_enable && pin_s2_reg[6] && all_ones_bit) |=> aos_reg)
		else $error("host all-ones request not taken");

	chk_ami_alternate: assert property (
		@(posedge transmit_timing_clock) disable iff (lk_reset)
		(lk_aos && lk_ce) [*2] |=> (line_tx_positive_out
			^ line_tx_negative_out)
			&& line_tx_positive_out != $past(line_tx_positive_out))
		else $error("all-ones output is not alternating AMI");

	chk_digital_line_idle: assert property (
		@(posedge transmit_timing_clock) disable iff (lk_reset)
		(lk_ce && !lk_aos && lk_mode == lla_pkg::LLA_DIGITAL)
		|=> !line_tx_positive_out && !line_tx_negative_out)
		else $error("line driven during digital loop");

	chk_remote_echo: assert property (
		@(posedge transmit_timing_clock) disable iff (lk_reset)
		(lk_ce && !lk_aos && lk_mode == lla_pkg::LLA_REMOTE)
		|=> {line_tx_positive_out, line_tx_negative_out}
			== $past(lrx_s2_reg))
		else $error("remote loop did not echo received bit");

	chk_digital_rx_ignored: assert property (
		@(posedge transmit_timing_clock) disable iff (lk_reset)
		lk_mode == lla_pkg::LLA_DIGITAL |-> !rx_push)
		else $error("line input taken in digital loop");

	chk_analog_source: assert property (
		@(posedge transmit_timing_clock) disable iff (lk_reset)
		(lk_mode == lla_pkg::LLA_ANALOG && rx_push)
		|-> rx_bit == {line_tx_positive_out, line_tx_negative_out})
		else $error("analog loop not fed from line output");

endmodule : lla_line_loop

// ---- hw/lla_pkg.sv ----
// Purpose: Shared constants for the line loopback and all-ones path.
// Assumes: Rails travel as {positive, negative}, one bit per cycle.
// Notes:   Mode codes are Gray along normal, digital, analog, remote.
//
// Functional notes
// - Three loopbacks, chosen by pins in hardware mode, by bits in host mode.
// - Analog loopback feeds line transmit output back as the received signal.
// - Analog loopback shows looped clock and data on receive outputs.
// - Analog loopback still drives transmitted data onto the line outputs.
// - Analog loopback ignores the external line receive inputs.
// - Analog loopback passes the jitter attenuator in either path when enabled.
// - Digital loopback forwards system transmit clock and rails to receive outputs.
// - Digital loopback keeps system transmit data off the line outputs.
// - Digital loopback ignores the line receive inputs entirely.
// - Remote loopback returns received line data to line, timed by transmit_timing_clock.
// - Remote loopback still presents received data on receive rail outputs.
// - Remote loop with transmit attenuator takes data right after recovery.
// - Remote loopback ignores system transmit clock and transmit rails.
// - All-ones requested by high pin in hardware mode or set bit in host.
// - While all-ones requested, line sends continuous AMI ones at link rate.
// - Attenuator offers ordinary modes plus a de-synchronizer mode.
// - De-sync mode accepts gapped jittery mapper data and smooths it.

package lla_pkg;

	typedef enum logic [1:0] {
		LLA_NORMAL  = 2'h0,
		LLA_DIGITAL = 2'h1,
		LLA_ANALOG  = 2'h3,
		LLA_REMOTE  = 2'h2
	} lla_mode_e;

	typedef enum logic [1:0] {
		LLA_JA_OFF    = 2'h0,
		LLA_JA_TX     = 2'h1,
		LLA_JA_DESYNC = 2'h3,
		LLA_JA_RX     = 2'h2
	} lla_ja_e;

	localparam int         LLA_RAIL_W         = 2;
	localparam int         LLA_FIFO_DEPTH     = 8;
	localparam logic [3:0] LLA_PREFILL        = 4'h4;
	localparam logic [3:0] LLA_PREFILL_DESYNC = 4'h6;
	localparam logic [1:0] LLA_RAILS_IDLE     = 2'h0;
	localparam logic [1:0] LLA_AMI_POS        = 2'h2;
	localparam logic [1:0] LLA_AMI_NEG        = 2'h1;
	localparam logic [6:0] LLA_PINS_RESET     = 7'h00;
	localparam logic [1:0] LLA_JA_RESET       = 2'h0;

endpackage : lla_pkg

// ---- bench/lla_mapper_model.sv ----
// Purpose: Behavioural mapper that drives the system transmit interface.
// Assumes: Bits are launched on falling edges of the system clock.
// Notes:   Between bits the rails show the inverse of the last bit.
`timescale 1ns/1ps

module lla_mapper_model (
	input  wire logic clock,
	output logic      system_transmit_clock,
	output logic      transmit_positive_rail,
	output logic      transmit_negative_rail
);
	initial begin
		system_transmit_clock  = 1'b0;
		transmit_positive_rail = 1'b0;
		transmit_negative_rail = 1'b0;
	end

	// One bit per rising clock pin, period above four system clocks
	task automatic send_bit(input logic [1:0] rails, input int gap);
		@(negedge clock);
		{transmit_positive_rail, transmit_negative_rail} = rails;
		repeat (3) @(negedge clock);
		system_transmit_clock = 1'b1;
		repeat (3) @(negedge clock);
		system_transmit_clock = 1'b0;
		{transmit_positive_rail, transmit_negative_rail} = ~rails;
		// Gaps stretch the clock like a de-mapped stream
		repeat (gap) @(negedge clock);
	endtask : send_bit
endmodule : lla_mapper_model

// ---- bench/test_line_loopback_all_ones_path.sv ----
// Purpose: Self-checking bench for loopback steering and all-ones.
// Assumes: Inputs change on falling clock edges; link clock is free.
// Notes:   Line and receive words are counted by code in monitors.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
	fails++; $display("[ERR] %s exp %h got %h", nm, exp, got); end end

module test_line_loopback_all_ones_path;
	logic       clock, reset, clock_enable, link_clk, host_mode;
	logic       far_pin, near_pin, ao_pin, far_bit, near_bit, ao_bit;
	logic [1:0] ja, lrx, status, prev_line;
	logic       stc, tpr, tnr, rxc, rxp, rxn, ltp, ltn, tx_ready, mon_ao;
	logic [1:0] seq[8];
	logic [1:0] line_q[$];
	int         fails, checks, cycles, ao_bad;
	int         cnt_line[4], cnt_rx[4];
	lla_pkg::lla_mode_e exp_mode[4] = '{lla_pkg::LLA_NORMAL,
		lla_pkg::LLA_DIGITAL, lla_pkg::LLA_REMOTE, lla_pkg::LLA_ANALOG};

	always #5 clock = ~clock;
	always #6 link_clk = ~link_clk;

	lla_mapper_model u_map (
		.clock                  (clock),
		.system_transmit_clock  (stc),
		.transmit_positive_rail (tpr),
		.transmit_negative_rail (tnr)
	);

	lla_line_loop u_dut (
		.clock                  (clock),
		.reset                  (reset),
		.clock_enable           (clock_enable),
		.transmit_timing_clock  (link_clk),
		.host_mode              (host_mode),
		.far_loop_select        (far_pin),
		.near_loop_select       (near_pin),
		.send_all_ones          (ao_pin),
		.far_loop_bit           (far_bit),
		.near_loop_bit          (near_bit),
		.all_ones_bit           (ao_bit),
		.ja_mode                (ja),
		.system_transmit_clock  (stc),
		.transmit_positive_rail (tpr),
		.transmit_negative_rail (tnr),
		.line_rx_positive_in    (lrx[1]),
		.line_rx_negative_in    (lrx[0]),
		.receive_clock_out      (rxc),
		.receive_positive_rail  (rxp),
		.receive_negative_rail  (rxn),
		.line_tx_positive_out   (ltp),
		.line_tx_negative_out   (ltn),
		.tx_ready               (tx_ready),
		.loop_mode_status       (status)
	);

	// Line side monitor, also judges the alternating ones pattern
	always @(posedge link_clk) begin
		if (!reset) begin
			cnt_line[{ltp, ltn}]++;
			if ({ltp, ltn} != 2'h0)
				line_q.push_back({ltp, ltn});
			if (mon_ao && ({ltp, ltn} === prev_line || (ltp ^ ltn) !== 1'b1))
				ao_bad++;
			prev_line = {ltp, ltn};
		end
	end

	always @(posedge clock) begin
		if (!reset && rxc === 1'b1)
			cnt_rx[{rxp, rxn}]++;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		if (fails == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clock);
	endtask : wait_clk

	task automatic clr;
		for (int i = 0; i < 4; i++) begin
			cnt_line[i] = 0;
			cnt_rx[i] = 0;
		end
		line_q.delete();
		ao_bad = 0;
	endtask : clr

	task automatic set_mode(input logic host, input logic [1:0] fn,
		input logic ao);
		@(negedge clock);
		host_mode = host;
		if (host)
			{far_bit, near_bit, ao_bit} = {fn, ao};
		else
			{far_pin, near_pin, ao_pin} = {fn, ao};
		wait_clk(40);
		`CHK("loop_mode_status", exp_mode[fn], status)
	endtask : set_mode

	// Four pad words push the tail past the deeper de-sync prefill
	task automatic send_seq(input int gap);
		for (int i = 0; i < 8; i++)
			u_map.send_bit(seq[i], gap * (i % 3));
		repeat (4) u_map.send_bit(2'h1, 0);
	endtask : send_seq

	task automatic send_n(input logic [1:0] rails, input int n);
		repeat (n) u_map.send_bit(rails, 0);
		wait_clk(60);
	endtask : send_n

	// Data words start at the first both-rails word, in order
	task automatic cmp_q(input string nm);
		int k;
		k = 0;
		while (k < line_q.size() && line_q[k] !== 2'h3)
			k++;
		`CHK(nm, 1'b1, line_q.size() >= k + 8)
		for (int i = 0; i < 8 && k + i < line_q.size(); i++)
			`CHK(nm, seq[i], line_q[k + i])
	endtask : cmp_q

	initial begin
		clock = 1'b0;
		link_clk = 1'b0;
		reset = 1'b1;
		clock_enable = 1'b1;
		host_mode = 1'b1;
		{far_pin, near_pin, ao_pin, far_bit, near_bit, ao_bit} = 6'h00;
		ja = 2'h0;
		lrx = 2'h3;
		mon_ao = 1'b0;
		seq = '{2'h3, 2'h2, 2'h1, 2'h3, 2'h1, 2'h2, 2'h3, 2'h2};
		clr();
		wait_clk(6);
		`CHK("reset_outputs", 7'h00, {rxc, rxp, rxn, ltp, ltn, status})
		reset = 1'b0;
		wait_clk(40);
		for (int h = 0; h < 2; h++)
			for (int m = 0; m < 4; m++)
				set_mode(h[0], m[1:0], 1'b0);
		set_mode(1'b1, 2'h0, 1'b0);
		// Low enable holds the mode against new select bits
		clock_enable = 1'b0;
		{far_bit, near_bit} = 2'h3;
		wait_clk(10);
		`CHK("freeze_status", 2'h0, status)
		clock_enable = 1'b1;
		{far_bit, near_bit} = 2'h0;
		wait_clk(10);
		`CHK("thaw_status", 2'h0, status)
		// Pin request has no effect while bits steer
		ao_pin = 1'b1;
		clr();
		wait_clk(40);
		`CHK("pin_ignored", 1'b1, cnt_line[1] + cnt_line[2] == 0)
		ao_pin = 1'b0;
		for (int j = 0; j < 4; j++) begin
			ja = j[1:0];
			clr();
			send_seq(j);
			wait_clk(80);
			cmp_q("ja_path");
		end
		ja = 2'h0;
		set_mode(1'b1, 2'h3, 1'b0);
		clr();
		send_n(2'h2, 6);
		`CHK("analog_line", 1'b1, cnt_line[2] > 0)
		`CHK("analog_rx", 1'b1, cnt_rx[2] > 0)
		`CHK("analog_ignore", 0, cnt_rx[3])
		set_mode(1'b1, 2'h1, 1'b0);
		clr();
		send_n(2'h2, 6);
		`CHK("digital_rx", 1'b1, cnt_rx[2] > 0)
		`CHK("digital_ignore", 0, cnt_rx[3])
		`CHK("digital_line", 0, cnt_line[1] + cnt_line[2] + cnt_line[3])
		lrx = 2'h1;
		for (int j = 0; j < 2; j++) begin
			ja = j[1:0];
			set_mode(1'b1, 2'h2, 1'b0);
			clr();
			send_n(2'h2, 6);
			`CHK("remote_line", 1'b1, cnt_line[1] > 0)
			`CHK("remote_ignore", 0, cnt_line[2])
			`CHK("remote_rx", 1'b1, cnt_rx[1] > 0)
		end
		ja = 2'h0;
		lrx = 2'h3;
		for (int h = 0; h < 2; h++) begin
			set_mode(h[0], 2'h0, 1'b1);
			clr();
			mon_ao = 1'b1;
			wait_clk(40);
			mon_ao = 1'b0;
			`CHK("ones_pattern", 0, ao_bad)
			`CHK("ones_seen", 1'b1, cnt_line[2] > 5)
			set_mode(h[0], 2'h0, 1'b0);
		end
		ao_pin = 1'b0;
		// Fill the transmit buffer while all-ones holds it, then drain
		set_mode(1'b1, 2'h0, 1'b1);
		send_seq(0);
		u_map.send_bit(2'h2, 0);
		wait_clk(5);
		`CHK("fifo_full", 1'b0, tx_ready)
		clr();
		set_mode(1'b1, 2'h0, 1'b0);
		wait_clk(60);
		`CHK("fifo_ready", 1'b1, tx_ready)
		cmp_q("fifo_drain");
		wrap_up();
	end
endmodule : test_line_loopback_all_ones_path
